//--- logic/msp_pkg.sv
// Constants, register map and carrier types of the motor starter protection monitor
package msp_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  // Supervision times in milliseconds
  localparam int unsigned T_FILTER_MS = 10;
  localparam int unsigned T_UNDERLOAD_HOLD_MS = 1000;
  localparam int unsigned T_ASYM_HOLD_MS = 500;
  localparam int unsigned T_START_WINDOW_MS = 10000;
  localparam int unsigned T_BLOCK_TIME_MS = 1000;

  // Same times as clock cycles
  localparam int unsigned FILTER_CYC = CYC_PER_MS * T_FILTER_MS;
  localparam int unsigned UNDERLOAD_HOLD_CYC = CYC_PER_MS * T_UNDERLOAD_HOLD_MS;
  localparam int unsigned ASYM_HOLD_CYC = CYC_PER_MS * T_ASYM_HOLD_MS;
  localparam int unsigned START_WINDOW_CYC = CYC_PER_MS * T_START_WINDOW_MS;
  localparam int unsigned BLOCK_TIME_CYC = CYC_PER_MS * T_BLOCK_TIME_MS;

  // Current ratios: 18.75 % = 3/16, 800 %, 400 %, 30 % = 3/10
  localparam logic [23:0] UNDERLOAD_NUM = 24'h3;
  localparam logic [23:0] UNDERLOAD_DEN = 24'h10;
  localparam logic [23:0] BLOCK_START_MULT = 24'h8;
  localparam logic [23:0] BLOCK_RUN_MULT = 24'h4;
  localparam logic [23:0] ASYM_NUM = 24'h3;
  localparam logic [23:0] ASYM_DEN = 24'hA;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // Control register bit positions
  localparam int unsigned CTRL_RUN_CW_BIT = 0;
  localparam int unsigned CTRL_RUN_CCW_BIT = 1;
  localparam int unsigned CTRL_BRAKE_BIT = 2;
  localparam int unsigned CTRL_QS_DISABLE_BIT = 3;
  localparam int unsigned CTRL_TRIP_ACK_BIT = 4;

  // Configuration register bit positions
  localparam int unsigned CFG_PROT_OFF_BIT = 16;
  localparam int unsigned CFG_CONN_MON_BIT = 17;
  localparam int unsigned CFG_REVERSING_BIT = 18;

  // Values after reset
  localparam logic [15:0] RATED_CURRENT_RST = 16'h0100;
  localparam logic CONN_MON_RST = 1'b1;

  // Output process image from the host
  typedef struct packed {
    logic quickstop_disable_bit;
    logic brake_cmd;
    logic run_ccw;
    logic run_cw;
  } msp_output_process_image_s;

  // Device settings
  typedef struct packed {
    logic reversing_starter_variant;
    logic conn_mon_en;
    logic prot_off;
    logic [15:0] rated_current;
  } msp_config_s;

  // Measured phase currents, same scale as the rated current
  typedef struct packed {
    logic [15:0] l3;
    logic [15:0] l2;
    logic [15:0] l1;
  } msp_phase_current_s;

endpackage

//--- logic/msp_input_filter.sv
// Signal delay filter for one digital input
`timescale 1ns/1ns
module msp_input_filter #(
  parameter int unsigned DELAY_CYC = 100000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Input and filtered level
  input wire logic raw_i,
  output logic level_o
);
  localparam int unsigned CW = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);

  logic [CW-1:0] cnt_q;

  // The new level is taken only after it held without a break for the whole delay
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      level_o <= 1'b0;
    end else if (raw_i == level_o) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
      level_o <= raw_i;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
endmodule

//--- logic/msp_hold_timer.sv
// Elapsed-time timer that flags when a run has lasted a set number of cycles
`timescale 1ns/1ns
module msp_hold_timer #(
  parameter int unsigned HOLD_CYC = 10000000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control and result
  input wire logic run_i,
  output logic done_o
);
  localparam int unsigned CW = $clog2(HOLD_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HOLD_CYC - 1);

  logic [CW-1:0] cnt_q;

  // Dropping run restarts the measurement from zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      done_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q <= '0;
      done_o <= 1'b0;
    end else if (cnt_q == LAST) begin
      done_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
endmodule

//--- logic/msp_monitor.sv
// Motor starter protection monitor: current supervision, input actions, outputs
`timescale 1ns/1ns
module msp_monitor
  import msp_pkg::*;
#(
  parameter int unsigned FILTER_CYC_P = msp_pkg::FILTER_CYC,
  parameter int unsigned UNDERLOAD_HOLD_CYC_P = msp_pkg::UNDERLOAD_HOLD_CYC,
  parameter int unsigned ASYM_HOLD_CYC_P = msp_pkg::ASYM_HOLD_CYC,
  parameter int unsigned START_WINDOW_CYC_P = msp_pkg::START_WINDOW_CYC,
  parameter int unsigned BLOCK_TIME_CYC_P = msp_pkg::BLOCK_TIME_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Measured currents and connector jumper
  input wire msp_pkg::msp_phase_current_s phase_current_i,
  input wire logic conn_present_i,
  // Digital inputs
  input wire logic digital_input_one_i,
  input wire logic digital_input_two_i,
  input wire logic digital_input_three_i,
  input wire logic digital_input_four_i,
  // Switching commands and indications
  output logic motor_cw_o,
  output logic motor_ccw_o,
  output logic brake_o,
  output logic fault_o,
  output logic [1:0] input_process_image_o
);
  import msp_pkg::*;

  msp_output_process_image_s opi_q;
  msp_config_s cfg_q;
  logic [31:0] rdata_q;
  logic trip_ack;
  logic [3:0] raw_in;
  logic [3:0] filt;
  logic [3:0] filt_prev_q;
  logic qs_q;
  logic brake_lock_q;
  logic trip_q;
  logic motor_cw_q;
  logic motor_ccw_q;
  logic brake_q;
  logic motor_on;
  logic ul_win_done;
  logic as_win_done;
  logic start_win_done;
  logic blk_time_done;
  logic [23:0] i1;
  logic [23:0] i2;
  logic [23:0] i3;
  logic [23:0] rated;
  logic [23:0] i_max;
  logic [23:0] i_min;
  logic [23:0] ul_lim;
  logic [23:0] blk_lim;
  logic ul_hit;
  logic blk_over;
  logic blk_trip;
  logic asym_hit;
  logic conn_fault;
  logic group_fault;
  logic cmd_cw;
  logic cmd_ccw;
  logic qs_edge;
  logic qs_clear;
  logic emergency;
  logic trip_restart;
  logic lim_cw;
  logic lim_ccw;
  logic motor_ok;

  // Register writes; trip acknowledge is a write-one pulse
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      opi_q <= '0;
      cfg_q <= '{reversing_starter_variant: 1'b0, conn_mon_en: CONN_MON_RST,
                 prot_off: 1'b0, rated_current: RATED_CURRENT_RST};
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_CTRL) begin
        opi_q <= reg_wdata_i[CTRL_QS_DISABLE_BIT:CTRL_RUN_CW_BIT];
      end else if (reg_addr_i == ADDR_CONFIG) begin
        cfg_q <= reg_wdata_i[CFG_REVERSING_BIT:0];
      end
    end
  end

  assign trip_ack = reg_wr_i && (reg_addr_i == ADDR_CTRL) && reg_wdata_i[CTRL_TRIP_ACK_BIT];

  // Read data stand only in the cycle after each strobe cycle; unmapped offsets read zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else if (!reg_rd_i) begin
      rdata_q <= '0;
    end else if (reg_addr_i == ADDR_CTRL) begin
      rdata_q <= {28'h0000000, opi_q};
    end else if (reg_addr_i == ADDR_CONFIG) begin
      rdata_q <= {13'h0000, cfg_q};
    end else if (reg_addr_i == ADDR_STATUS) begin
      rdata_q <= {16'h0000, filt, brake_lock_q, qs_q, conn_fault, asym_hit,
                  blk_over, ul_hit, group_fault, trip_q,
                  brake_q, motor_ccw_q, motor_cw_q, 1'b0};
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata_o = rdata_q;

  // Normally-open inputs, each delayed by the filter
  assign raw_in = {digital_input_four_i, digital_input_three_i,
                   digital_input_two_i, digital_input_one_i};

  for (genvar k = 0; k < 4; k++) begin : g_filt
    msp_input_filter #(.DELAY_CYC(FILTER_CYC_P)) u_filt (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .raw_i(raw_in[k]),
      .level_o(filt[k])
    );
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      filt_prev_q <= '0;
    end else begin
      filt_prev_q <= filt;
    end
  end

  assign input_process_image_o = filt[1:0];

  // Supervision windows measured from each motor switch-on; the block time from each start of blk_over
  assign motor_on = motor_cw_q || motor_ccw_q;

  msp_hold_timer #(.HOLD_CYC(UNDERLOAD_HOLD_CYC_P)) u_ul_win (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(motor_on),
    .done_o(ul_win_done)
  );

  msp_hold_timer #(.HOLD_CYC(ASYM_HOLD_CYC_P)) u_as_win (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(motor_on),
    .done_o(as_win_done)
  );

  msp_hold_timer #(.HOLD_CYC(START_WINDOW_CYC_P)) u_start_win (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(motor_on),
    .done_o(start_win_done)
  );

  msp_hold_timer #(.HOLD_CYC(BLOCK_TIME_CYC_P)) u_blk_time (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(blk_over),
    .done_o(blk_time_done)
  );

  // Current evaluation, widened so no product overflows
  assign i1 = 24'(phase_current_i.l1);
  assign i2 = 24'(phase_current_i.l2);
  assign i3 = 24'(phase_current_i.l3);
  assign rated = 24'(cfg_q.rated_current);

  always_comb begin
    i_max = i1;
    i_min = i1;
    if (i2 > i_max) begin
      i_max = i2;
    end
    if (i3 > i_max) begin
      i_max = i3;
    end
    if (i2 < i_min) begin
      i_min = i2;
    end
    if (i3 < i_min) begin
      i_min = i3;
    end
  end

  assign ul_lim = rated * UNDERLOAD_NUM;
  assign ul_hit = motor_on && !cfg_q.prot_off && ul_win_done
                  && (i_max * UNDERLOAD_DEN < ul_lim);

  assign blk_lim = start_win_done ? rated * BLOCK_RUN_MULT : rated * BLOCK_START_MULT;
  assign blk_over = motor_on && !cfg_q.prot_off && (i_max > blk_lim);
  assign blk_trip = blk_over && blk_time_done;

  // Reference is the largest phase, so a cross-multiply avoids division
  assign asym_hit = motor_on && as_win_done
                    && ((i_max - i_min) * ASYM_DEN > i_max * ASYM_NUM);

  // Internal shutdown; a new cause wins over a simultaneous acknowledge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trip_q <= 1'b0;
    end else if (ul_hit || blk_trip || asym_hit) begin
      trip_q <= 1'b1;
    end else if (trip_ack) begin
      trip_q <= 1'b0;
    end
  end

  assign conn_fault = cfg_q.conn_mon_en && !conn_present_i;
  assign group_fault = trip_q || conn_fault;

  // Input actions, fixed per variant
  assign qs_edge = filt[0] && !filt_prev_q[0] && !opi_q.quickstop_disable_bit;
  assign qs_clear = (!opi_q.run_cw && !opi_q.run_ccw) || opi_q.quickstop_disable_bit;

  // Edge latch ignores the level once set and clears on qs_clear even while it is high; set beats clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      qs_q <= 1'b0;
    end else if (qs_edge) begin
      qs_q <= 1'b1;
    end else if (qs_clear) begin
      qs_q <= 1'b0;
    end
  end

  assign emergency = !cfg_q.reversing_starter_variant && filt[2];
  assign trip_restart = !cfg_q.reversing_starter_variant && filt[3];
  assign lim_cw = cfg_q.reversing_starter_variant && filt[2];
  assign lim_ccw = cfg_q.reversing_starter_variant && filt[3];

  // Brake stays locked after a limit trip until every command is withdrawn
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      brake_lock_q <= 1'b0;
    end else if (lim_cw || lim_ccw) begin
      brake_lock_q <= 1'b1;
    end else if (!opi_q.brake_cmd && !opi_q.run_cw && !opi_q.run_ccw) begin
      brake_lock_q <= 1'b0;
    end
  end

  // Both run bits together mean no direction at all
  assign cmd_cw = opi_q.run_cw && !opi_q.run_ccw;
  assign cmd_ccw = opi_q.run_ccw && !opi_q.run_cw;

  // Each blocker acts on its own and they are ORed; the connector check stays
  // in force under emergency start because it protects the starter itself
  assign motor_ok = !qs_q && !trip_restart && !conn_fault
                    && (!trip_q || emergency);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      motor_cw_q <= 1'b0;
      motor_ccw_q <= 1'b0;
      brake_q <= 1'b0;
    end else begin
      motor_cw_q <= cmd_cw && motor_ok && !lim_cw;
      motor_ccw_q <= cmd_ccw && motor_ok && !lim_ccw;
      brake_q <= opi_q.brake_cmd && motor_ok && !brake_lock_q
                 && !lim_cw && !lim_ccw;
    end
  end

  assign motor_cw_o = motor_cw_q;
  assign motor_ccw_o = motor_ccw_q;
  assign brake_o = brake_q;

  // Quickstop is deliberately absent from the fault output
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_o <= 1'b0;
    end else begin
      fault_o <= group_fault;
    end
  end

  sequence qs_trigger_s;
    filt[0] && !filt_prev_q[0] && !opi_q.quickstop_disable_bit;
  endsequence

  sequence all_stopped_s;
    !motor_cw_q && !motor_ccw_q && !brake_q;
  endsequence

  ul_trip_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ul_hit |=> trip_q ##1 all_stopped_s or trip_q ##1 emergency)
    else $error("underload did not trip");

  prot_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cfg_q.prot_off && !asym_hit && !trip_q |=> !trip_q)
    else $error("supervision active while protection off");

  ul_window_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(motor_on) |-> !ul_hit [*2])
    else $error("underload evaluated right after switch-on");

  blk_start_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    motor_on && !start_win_done && !cfg_q.prot_off
    && i_max <= rated * BLOCK_START_MULT |-> !blk_over)
    else $error("start blocking limit below 800 percent");

  blk_trip_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    blk_over && blk_time_done |=> trip_q)
    else $error("blocking timeout did not trip");

  asym_window_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(motor_on) |-> !asym_hit [*2])
    else $error("asymmetry evaluated right after switch-on");

  qs_latch_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    qs_trigger_s |=> qs_q ##1 all_stopped_s)
    else $error("quickstop edge not latched");

  qs_nofault_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    qs_q && !trip_q && !conn_fault |=> !fault_o)
    else $error("quickstop raised fault output");

  qs_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    qs_q && opi_q.quickstop_disable_bit |=> !qs_q)
    else $error("quickstop latch not cleared");

  emerg_run_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    trip_q && emergency && cmd_cw && !qs_q && !conn_fault && !trip_restart |=> motor_cw_q)
    else $error("emergency start did not run motor");

  limit_cw_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    lim_cw |=> !motor_cw_q && !brake_q)
    else $error("motor or brake on at cw limit");

  conn_fault_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    conn_fault |=> fault_o && !motor_cw_q && !motor_ccw_q)
    else $error("connector loss not faulted");

endmodule

//--- test/msp_field_model.sv
// Field side model: sensor contacts, current sensing and connector jumper
`timescale 1ns/1ns
module msp_field_model
  import msp_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Requested field state
  input wire logic [3:0] contact_i,
  input wire msp_pkg::msp_phase_current_s current_i,
  input wire logic jumper_i,
  // Lines towards the starter
  output logic [3:0] input_o,
  output msp_pkg::msp_phase_current_s current_o,
  output logic conn_present_o
);
  // Contacts close onto the supply, so an energised sensor reads high
  always_ff @(posedge clk_i) begin
    input_o <= contact_i;
    current_o <= current_i;
    conn_present_o <= jumper_i;
  end
endmodule

//--- test/tb_msp_monitor.sv
// Self-checking bench for the motor starter protection monitor
`timescale 1ns/1ns
module tb_msp_monitor;
  import msp_pkg::*;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
    logic [7:0] a;
  } msp_chk_s;
  // Observed word: {image, fault_o, status[28:0]}
  localparam logic [31:0] M = 32'h2000003E;
  localparam logic [31:0] QM = 32'hE000043E;
  localparam logic [31:0] RM = 32'h2000083E;
  localparam logic [31:0] TRIP = 32'h20000030;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [3:0] contact;
  logic [3:0] din;
  msp_phase_current_s cur;
  msp_phase_current_s phase;
  logic jumper;
  logic conn;
  logic motor_cw_o, motor_ccw_o, brake_o, fault_o;
  logic [1:0] input_process_image_o;
  msp_chk_s exp_q[$];
  int n_errors = 0;
  int comparisons = 0;
  logic rd_q = 1'b0;
  logic [15:0] nom;

  always #50 clk_i = ~clk_i;

  msp_field_model u_msp_field_model (.clk_i(clk_i), .contact_i(contact), .current_i(cur),
    .jumper_i(jumper), .input_o(din), .current_o(phase), .conn_present_o(conn));

  msp_monitor #(.FILTER_CYC_P(4), .UNDERLOAD_HOLD_CYC_P(20), .ASYM_HOLD_CYC_P(10),
    .START_WINDOW_CYC_P(50), .BLOCK_TIME_CYC_P(8)) u_msp_monitor (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .phase_current_i(phase), .conn_present_i(conn), .digital_input_one_i(din[0]),
    .digital_input_two_i(din[1]), .digital_input_three_i(din[2]),
    .digital_input_four_i(din[3]), .motor_cw_o(motor_cw_o), .motor_ccw_o(motor_ccw_o),
    .brake_o(brake_o), .fault_o(fault_o), .input_process_image_o(input_process_image_o));

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back('{e: e, m: m, a: a});
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic amps(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    cur <= '{l3: c, l2: b, l1: a};
  endtask
  task automatic test_done;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_i) rd_q <= reg_rd_i;
  always @(negedge clk_i) begin
    msp_chk_s c;
    logic [31:0] o;
    logic [2:0] p;
    if (rd_q) begin
      c = exp_q.pop_front();
      o = {input_process_image_o, fault_o, reg_rdata_o[28:0]};
      comparisons++;
      if ((o & c.m) !== (c.e & c.m)) begin
        n_errors++;
        $display("ERROR reg %h exp %h got %h", c.a, c.e & c.m, o & c.m);
      end
      // Switching pins must agree with the expected status bits
      if (c.a == ADDR_STATUS) begin
        p = {brake_o, motor_ccw_o, motor_cw_o} & c.m[3:1];
        comparisons++;
        if (p !== (c.e[3:1] & c.m[3:1])) begin
          n_errors++;
          $display("ERROR pins exp %h got %h", c.e[3:1] & c.m[3:1], p);
        end
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    test_done();
  end

  initial begin
    void'($urandom(87698));
    nom = 16'h00C8 + 16'($urandom % 100);
    contact = 4'h0;
    jumper = 1'b1;
    cur = '{l3: nom, l2: nom, l1: nom};
    wt(3);
    rst_b_i <= 1'b1;
    rd(ADDR_CONFIG, 32'h00020100, 32'h1FFFFFFF);
    rd(8'h0C, 32'h0, 32'h1FFFFFFF);
    rd(ADDR_STATUS, 32'h0, 32'hFFFFFFFF);
    // Underload, its start window and protection off
    amps(40, 40, 40);
    wr(ADDR_CTRL, 32'h1);
    wt(5);
    rd(ADDR_STATUS, 32'h2, M);
    wt(30);
    rd(ADDR_STATUS, TRIP, M);
    // One phase under the limit, the others just above it and no asymmetry
    amps(50, 50, 40);
    wr(ADDR_CTRL, 32'h11);
    wt(30);
    rd(ADDR_STATUS, 32'h2, M);
    wr(ADDR_CONFIG, 32'h00030100);
    amps(40, 40, 40);
    wt(40);
    rd(ADDR_STATUS, 32'h2, M);
    amps(nom, nom, nom);
    wr(ADDR_CONFIG, 32'h00020100);
    // Blocking: 400 % only after the start window, 800 % at start
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    wt(3);
    amps(1500, 1500, 1500);
    wt(30);
    rd(ADDR_STATUS, 32'h2, M);
    wt(30);
    rd(ADDR_STATUS, TRIP, M);
    amps(nom, nom, nom);
    wr(ADDR_CTRL, 32'h10);
    wr(ADDR_CTRL, 32'h1);
    wt(3);
    amps(2100, 2100, 2100);
    wt(4);
    rd(ADDR_STATUS, 32'h2, M);
    wt(10);
    rd(ADDR_STATUS, TRIP, M);
    // Asymmetry: 76/256 stays, 86/256 trips after the window
    amps(256, 256, 180);
    wr(ADDR_CTRL, 32'h11);
    wt(20);
    rd(ADDR_STATUS, 32'h2, M);
    wr(ADDR_CTRL, 32'h0);
    amps(256, 256, 170);
    wr(ADDR_CTRL, 32'h1);
    wt(3);
    rd(ADDR_STATUS, 32'h2, M);
    wt(15);
    rd(ADDR_STATUS, TRIP, M);
    amps(nom, nom, nom);
    wr(ADDR_CTRL, 32'h11);
    wt(3);
    // Quickstop: short glitch ignored, edge latches, cleared by disable or withdrawal
    contact <= 4'h1;
    wt(2);
    contact <= 4'h0;
    wt(8);
    rd(ADDR_STATUS, 32'h2, QM);
    contact <= 4'h3;
    wt(10);
    rd(ADDR_STATUS, 32'hC0000400, QM);
    wr(ADDR_CTRL, 32'h9);
    wt(3);
    rd(ADDR_STATUS, 32'hC0000002, QM);
    wr(ADDR_CTRL, 32'h1);
    wt(3);
    rd(ADDR_STATUS, 32'hC0000002, QM);
    contact <= 4'h0;
    wt(8);
    contact <= 4'h1;
    wt(10);
    rd(ADDR_STATUS, 32'h40000400, QM);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    wt(3);
    rd(ADDR_STATUS, 32'h40000002, QM);
    contact <= 4'h0;
    wt(8);
    // Direct variant: trip with restart, emergency start, both at once
    contact <= 4'h8;
    wt(8);
    rd(ADDR_STATUS, 32'h0, M);
    contact <= 4'h0;
    wt(8);
    rd(ADDR_STATUS, 32'h2, M);
    amps(40, 40, 40);
    wt(30);
    rd(ADDR_STATUS, TRIP, M);
    contact <= 4'h4;
    wt(8);
    rd(ADDR_STATUS, 32'h20000032, M);
    contact <= 4'hC;
    wt(8);
    rd(ADDR_STATUS, TRIP, M);
    contact <= 4'h0;
    amps(nom, nom, nom);
    wt(8);
    wr(ADDR_CTRL, 32'h10);
    // Reversing variant: limit trips, brake lock, opposite direction only
    wr(ADDR_CONFIG, 32'h00060100);
    wr(ADDR_CTRL, 32'h5);
    wt(3);
    rd(ADDR_STATUS, 32'hA, RM);
    contact <= 4'h4;
    wt(8);
    rd(ADDR_STATUS, 32'h800, RM);
    wr(ADDR_CTRL, 32'h6);
    wt(3);
    rd(ADDR_STATUS, 32'h804, RM);
    wr(ADDR_CTRL, 32'h5);
    wt(3);
    rd(ADDR_STATUS, 32'h800, RM);
    contact <= 4'h0;
    wt(8);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h6);
    wt(3);
    rd(ADDR_STATUS, 32'hC, RM);
    contact <= 4'h8;
    wt(8);
    wr(ADDR_CTRL, 32'h5);
    wt(3);
    rd(ADDR_STATUS, 32'h802, RM);
    contact <= 4'h0;
    // Connector jumper supervision on and off
    wr(ADDR_CONFIG, 32'h00020100);
    wr(ADDR_CTRL, 32'h1);
    jumper <= 1'b0;
    wt(3);
    rd(ADDR_STATUS, 32'h20000220, M | 32'h200);
    wr(ADDR_CONFIG, 32'h00000100);
    wt(3);
    rd(ADDR_STATUS, 32'h2, M);
    jumper <= 1'b1;
    wt(4);
    test_done();
  end
endmodule
